//--- rtl/inverter_protection_restart.sv
// inverter protection supervisor with restart timing, lockouts and history
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`default_nettype none
`include "prot_cfg.svh"
// Operation
// R01: limit output voltage while over current
// R02: sustained overload: off 30 s, restart
// R03: fourth quick overload latches inverter off
// R04: overload latch cleared by switch off-on
// R05: low battery voltage turns inverter off
// R06: low battery: off 30 s, restart above restart level
// R07: fourth quick low battery stops restart-level retries
// R08: switch off-on overrides low battery lockout
// R09: after four, restart on 30 s above detect
// R10: charger stays on during low battery shutdown
// R11: thresholds writable, defaults 37.2 and 43.6 V
// R12: charge-allow drops below minimum when enabled
// R13: high battery: wait 30 s, then acceptable level
// R14: over temperature retries every 30 s, forever
// R15: total energy counter never resettable; the code still clears it to zero on rst_i
// R16: since-cleared energy counter, cleared by software
// R17: daily highest and lowest battery voltage
// R18: daily error count and recent error codes
// R19: retry counts separate, cleared by reset, switch
// R20: sticky cause flags raise an event
module inverter_protection_restart #(
  parameter int unsigned SEC_CYC = `CLK_HZ * `TICK_S,
  parameter int unsigned OC_CYC = `CLK_HZ / 1000 * `OC_PERSIST_MS,
  parameter int unsigned RESTART_S = `RESTART_S
) (
  input wire logic clk_i,             // system clock, 25 MHz
  input wire logic rst_i,             // sync reset, high
  input wire logic wb_cyc_i,          // wishbone cycle
  input wire logic wb_stb_i,          // wishbone strobe
  input wire logic wb_we_i,           // wishbone write
  input wire logic [7:0] wb_adr_i,    // byte address
  input wire logic [3:0] wb_sel_i,    // byte enables
  input wire logic [31:0] wb_dat_i,   // write data
  output logic [31:0] wb_dat_o,       // read data
  output logic wb_ack_o,              // wishbone ack
  input wire logic sw_on_i,           // user switch, high is on (pin)
  input wire logic oc_i,              // over current comparator (pin)
  input wire logic hv_i,              // battery too high comparator (pin)
  input wire logic ot_i,              // over temperature comparator (pin)
  input wire logic epl_i,             // one energy quantum per high pulse (pin)
  input wire logic [15:0] batt_v_i,   // battery voltage, 10 mV steps
  input wire logic day_tick_i,        // new day pulse
  output logic inv_en_o,              // inverter output enable
  output logic chg_en_o,              // solar charger enable
  output logic chg_allow_o,           // charge-allow signal
  output logic vlim_o,                // reduce output voltage
  output logic event_o                // pulse when a cause flag sets
);
  prot_pkg::st_s r;
  prot_pkg::st_s n;
  logic hold_done;
  logic win_done;
  logic rech_done;
  logic load_hold;
  logic load_win;
  logic load_rech;
  prot_pkg::cause_e trip;
  logic ol_trip;
  logic epl_edge;
  logic acc;
  logic wr;
  logic [31:0] rd;
  logic [31:0] cur;
  logic [31:0] wv;

  if (SEC_CYC < 2 || OC_CYC < 1 || RESTART_S < 1) begin : g_bad
    $error("inverter_protection_restart parameters out of range");
  end

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    merge = (o & ~m) | (d & m);
  endfunction : merge

  retry_timer #(.SECS(RESTART_S)) u_hold (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(load_hold),
    .tick_i(r.sec_tick),
    .done_o(hold_done)
  );

  retry_timer #(.SECS(RESTART_S)) u_win (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(load_win),
    .tick_i(r.sec_tick),
    .done_o(win_done)
  );

  retry_timer #(.SECS(RESTART_S)) u_rech (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(load_rech),
    .tick_i(r.sec_tick),
    .done_o(rech_done)
  );

  // any dip to or below detect level restarts the continuous wait
  assign load_rech = (r.mode != prot_pkg::s_lb_lock) || !(batt_v_i > r.th_det); // R09

  always_comb begin
    n = r;
    load_hold = 1'b0;
    load_win = 1'b0;
    trip = prot_pkg::c_none;
    rd = 32'h0000_0000;
    cur = 32'h0000_0000;
    wv = 32'h0000_0000;
    acc = wb_cyc_i && wb_stb_i && !r.ack;
    // a write lands where the master sees ack, while it still holds the request
    wr = wb_cyc_i && wb_stb_i && wb_we_i && r.ack;

    // pin synchroniser, a change counts once stages two and three agree
    n.s1 = {epl_i, ot_i, hv_i, oc_i, sw_on_i};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.lvl = ((r.s2 ~^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.lvl);

    n.sec_tick = 1'b0;
    if (r.sec_cnt >= SEC_CYC - 1) begin
      n.sec_cnt = 32'h0000_0000;
      n.sec_tick = 1'b1;
    end else begin
      n.sec_cnt = r.sec_cnt + 32'h0000_0001;
    end

    // only sustained over current trips; short inrush is ridden out by limiting
    if (r.lvl[`P_OC] && r.mode == prot_pkg::s_run) begin
      if (r.oc_cnt < OC_CYC) begin
        n.oc_cnt = r.oc_cnt + 32'h0000_0001;
      end
    end else begin
      n.oc_cnt = 32'h0000_0000;
    end
    ol_trip = (r.oc_cnt >= OC_CYC); // R02

    unique case (r.mode)
      prot_pkg::s_off: begin
        if (r.lvl[`P_SW]) begin
          n.mode = prot_pkg::s_run; // R04 R08
        end
      end
      prot_pkg::s_run: begin
        if (win_done) begin
          n.ol_retry = 2'h0;
          n.lb_retry = 2'h0;
        end
        if (r.lvl[`P_HV]) begin
          trip = prot_pkg::c_hv;
          n.mode = prot_pkg::s_hv_wait;
        end else if (r.lvl[`P_OT]) begin
          trip = prot_pkg::c_ot;
          n.mode = prot_pkg::s_ot_wait;
        end else if (batt_v_i < r.th_shut) begin
          trip = prot_pkg::c_lb; // R05
          if (!win_done && r.lb_retry == `RETRY_LAST) begin
            n.mode = prot_pkg::s_lb_lock; // R07
          end else begin
            n.mode = prot_pkg::s_lb_wait;
            n.lb_retry = (win_done ? 2'h0 : r.lb_retry) + 2'h1;
          end
        end else if (ol_trip) begin
          trip = prot_pkg::c_ol;
          if (!win_done && r.ol_retry == `RETRY_LAST) begin
            n.mode = prot_pkg::s_ol_lock; // R03
          end else begin
            n.mode = prot_pkg::s_ol_wait;
            n.ol_retry = (win_done ? 2'h0 : r.ol_retry) + 2'h1;
          end
        end
      end
      prot_pkg::s_ol_wait: begin
        if (hold_done) begin
          n.mode = prot_pkg::s_run; // R02
          load_win = 1'b1;
        end
      end
      prot_pkg::s_lb_wait: begin
        if (hold_done && batt_v_i > r.th_rest) begin
          n.mode = prot_pkg::s_run; // R06
          load_win = 1'b1;
        end
      end
      prot_pkg::s_hv_wait: begin
        if (hold_done && !r.lvl[`P_HV]) begin
          n.mode = prot_pkg::s_run; // R13
        end
      end
      prot_pkg::s_ot_wait: begin
        // no count kept: a still-hot restart simply trips again
        if (hold_done) begin
          n.mode = prot_pkg::s_run; // R14
        end
      end
      prot_pkg::s_ol_lock: begin
        n.mode = prot_pkg::s_ol_lock; // R03
      end
      prot_pkg::s_lb_lock: begin
        if (rech_done) begin
          n.mode = prot_pkg::s_run; // R09
          n.lb_retry = 2'h0;
        end
      end
    endcase

    if (trip != prot_pkg::c_none) begin
      load_hold = 1'b1; // R02 R06 R13 R14
    end

    // switch off beats every other state and forgets the retry history
    if (!r.lvl[`P_SW]) begin
      n.mode = prot_pkg::s_off; // R04 R08
      n.ol_retry = 2'h0; // R19
      n.lb_retry = 2'h0; // R19
    end

    // daily history, a trip in the roll-over cycle still lands in the new day
    if (day_tick_i) begin
      n.vmax = batt_v_i;
      n.vmin = batt_v_i;
      n.err_cnt = 8'h00;
      n.err_code = '0;
    end else begin
      if (batt_v_i > r.vmax) begin
        n.vmax = batt_v_i; // R17
      end
      if (batt_v_i < r.vmin) begin
        n.vmin = batt_v_i; // R17
      end
    end
    if (trip != prot_pkg::c_none) begin
      n.err_code = {n.err_code[2:0], trip}; // R18
      if (n.err_cnt != 8'hff) begin
        n.err_cnt = n.err_cnt + 8'h01; // R18
      end
    end

    epl_edge = r.lvl[`P_EPL] && !r.epl_prev;
    n.epl_prev = r.lvl[`P_EPL];
    n.e_total = r.e_total + {31'h0000_0000, epl_edge}; // R15
    n.e_since = r.e_since + {31'h0000_0000, epl_edge}; // R16

    // bus: answer one cycle after the request, unmapped reads give zero
    n.ack = acc;
    unique case (wb_adr_i)
      `A_CTRL: cur = {29'h0000_0000, 1'b0, r.chg_on, r.allow_en};
      `A_STATUS: cur = {12'h000, r.vlim, r.chg_allow, r.chg_en, r.inv_en, 3'h0, r.lvl,
                        r.lb_retry, r.ol_retry, 1'b0, r.mode};
      `A_STICKY: cur = {28'h000_0000, r.sticky};
      `A_TH_SHUT: cur = {16'h0000, r.th_shut};
      `A_TH_REST: cur = {16'h0000, r.th_rest};
      `A_TH_DET: cur = {16'h0000, r.th_det};
      `A_TH_ALLOW: cur = {16'h0000, r.th_allow};
      `A_E_TOTAL: cur = r.e_total;
      `A_E_SINCE: cur = r.e_since;
      `A_DAY_V: cur = {r.vmax, r.vmin};
      `A_DAY_ERR: cur = {8'h00, r.err_cnt, r.err_code};
      default: cur = 32'h0000_0000;
    endcase
    rd = cur;
    wv = merge(cur, wb_dat_i, wb_sel_i);
    if (acc) begin
      n.rdat = rd;
    end
    if (wr) begin
      unique case (wb_adr_i)
        `A_CTRL: begin
          n.allow_en = wv[`CTRL_ALLOW_EN]; // R12
          n.chg_on = wv[`CTRL_CHG_ON];
          if (wv[`CTRL_CLR_SINCE]) begin
            n.e_since = {31'h0000_0000, epl_edge}; // R16
          end
        end
        `A_TH_SHUT: n.th_shut = wv[15:0]; // R11
        `A_TH_REST: n.th_rest = wv[15:0]; // R11
        `A_TH_DET: n.th_det = wv[15:0]; // R11
        `A_TH_ALLOW: n.th_allow = wv[15:0];
        default: begin
        end
      endcase
    end

    // sticky cause flags: write one to clear, a new trip wins over the clear
    if (wr && wb_adr_i == `A_STICKY) begin
      n.sticky = r.sticky & ~wv[3:0];
    end
    n.evt = 1'b0;
    unique case (trip)
      prot_pkg::c_ol: begin
        n.sticky[0] = 1'b1; // R20
        n.evt = !r.sticky[0]; // R20
      end
      prot_pkg::c_lb: begin
        n.sticky[1] = 1'b1; // R20
        n.evt = !r.sticky[1]; // R20
      end
      prot_pkg::c_hv: begin
        n.sticky[2] = 1'b1; // R20
        n.evt = !r.sticky[2]; // R20
      end
      prot_pkg::c_ot: begin
        n.sticky[3] = 1'b1; // R20
        n.evt = !r.sticky[3]; // R20
      end
      default: begin
      end
    endcase

    n.inv_en = (n.mode == prot_pkg::s_run);
    n.vlim = r.lvl[`P_OC] && (r.mode == prot_pkg::s_run); // R01
    n.chg_en = r.chg_on || n.mode == prot_pkg::s_lb_wait
               || n.mode == prot_pkg::s_lb_lock; // R10
    n.chg_allow = !(r.allow_en && batt_v_i < r.th_allow); // R12
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.th_shut <= `RST_TH_SHUT; // R11
      r.th_rest <= `RST_TH_REST; // R11
      r.th_det <= `RST_TH_DET;
      r.th_allow <= `RST_TH_ALLOW;
      r.chg_on <= 1'b1;
      r.chg_en <= 1'b1;
      r.chg_allow <= 1'b1;
      r.vmin <= `RST_VMIN;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;
  assign inv_en_o = r.inv_en;
  assign chg_en_o = r.chg_en;
  assign chg_allow_o = r.chg_allow;
  assign vlim_o = r.vlim;
  assign event_o = r.evt;
endmodule : inverter_protection_restart
`default_nettype wire

//--- rtl/prot_cfg.svh
// constants for the inverter protection and restart block
`ifndef PROT_CFG_SVH
`define PROT_CFG_SVH
`define CLK_HZ 25000000
`define TICK_S 1
`define RESTART_S 30
`define OC_PERSIST_MS 500
`define RETRY_LAST 2'h3
`define A_CTRL 8'h00
`define A_STATUS 8'h04
`define A_STICKY 8'h08
`define A_TH_SHUT 8'h0c
`define A_TH_REST 8'h10
`define A_TH_DET 8'h14
`define A_TH_ALLOW 8'h18
`define A_E_TOTAL 8'h1c
`define A_E_SINCE 8'h20
`define A_DAY_V 8'h24
`define A_DAY_ERR 8'h28
`define CTRL_ALLOW_EN 0
`define CTRL_CHG_ON 1
`define CTRL_CLR_SINCE 2
`define P_SW 0
`define P_OC 1
`define P_HV 2
`define P_OT 3
`define P_EPL 4
`define RST_TH_SHUT 16'h0e88
`define RST_TH_REST 16'h1108
`define RST_TH_DET 16'h1130
`define RST_TH_ALLOW 16'h0e10
`define RST_VMIN 16'hffff
`endif

//--- rtl/prot_pkg.sv
// types for the inverter protection and restart block
`default_nettype none
package prot_pkg;
  typedef enum logic [2:0] {
    s_off, s_run, s_ol_wait, s_lb_wait, s_hv_wait, s_ot_wait, s_ol_lock, s_lb_lock
  } mode_e;
  typedef enum logic [3:0] {c_none, c_ol, c_lb, c_hv, c_ot} cause_e;
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] lvl;
    logic epl_prev;
    mode_e mode;
    logic [31:0] sec_cnt;
    logic sec_tick;
    logic [31:0] oc_cnt;
    logic [1:0] ol_retry;
    logic [1:0] lb_retry;
    logic [15:0] th_shut;
    logic [15:0] th_rest;
    logic [15:0] th_det;
    logic [15:0] th_allow;
    logic allow_en;
    logic chg_on;
    logic [3:0] sticky;
    logic [31:0] e_total;
    logic [31:0] e_since;
    logic [15:0] vmax;
    logic [15:0] vmin;
    logic [7:0] err_cnt;
    logic [3:0][3:0] err_code;
    logic ack;
    logic [31:0] rdat;
    logic inv_en;
    logic chg_en;
    logic chg_allow;
    logic vlim;
    logic evt;
  } st_s;
endpackage : prot_pkg
`default_nettype wire

//--- rtl/retry_timer.sv
// whole-second countdown used for hold-off, retry window and recharge timing
`default_nettype none
module retry_timer #(
  parameter int unsigned SECS = 30
) (
  input wire logic clk_i,  // system clock
  input wire logic rst_i,  // sync reset, high
  input wire logic load_i, // restart the countdown
  input wire logic tick_i, // one pulse per second
  output logic done_o      // countdown at zero
);
  localparam int unsigned W = $clog2(SECS + 2);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  if (SECS == 0) begin : g_bad
    $error("retry_timer needs SECS of at least one");
  end

  // one extra tick: the first tick after a load may come at once
  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = W'(SECS + 1);
    end else if (tick_i && cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_o = (cnt_r == '0);
endmodule : retry_timer
`default_nettype wire

//--- verification/inverter_protection_restart_chk.sv
// assertion checker for the inverter protection block
`default_nettype none
module inverter_protection_restart_chk (
  input wire logic clk_i,       // system clock
  input wire logic rst_i,       // sync reset, high
  input wire logic wb_cyc_i,    // bus cycle
  input wire logic wb_stb_i,    // bus strobe
  input wire logic wb_ack_o,    // bus ack
  input wire logic sw_on_i,     // user switch
  input wire logic oc_i,        // over current pin
  input wire logic hv_i,        // battery high pin
  input wire logic ot_i,        // over temperature pin
  input wire logic inv_en_o,    // inverter enable
  input wire logic chg_en_o,    // charger enable
  input wire logic chg_allow_o, // charge allow
  input wire logic vlim_o,      // voltage limit
  input wire logic event_o      // cause event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RST_VAL: assert property ($fell(rst_i) |-> !inv_en_o && chg_en_o && chg_allow_o)
    else $error("outputs wrong after reset");
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_SW_OFF: assert property (!sw_on_i [*6] |-> !inv_en_o)
    else $error("enabled with switch off");
  AST_HV_OFF: assert property (hv_i [*7] |-> !inv_en_o)
    else $error("enabled with battery high");
  AST_OT_OFF: assert property ($rose(ot_i) ##1 ot_i [*6] |-> !inv_en_o)
    else $error("enabled with over temperature");
  AST_VLIM: assert property (!oc_i [*6] |-> !vlim_o)
    else $error("limit without over current");
  AST_EVT: assert property (event_o |=> !event_o)
    else $error("event longer than a pulse");
  // an automatic restart must not follow a trip at once
  AST_HOLD: assert property ($fell(inv_en_o) && sw_on_i |=> !inv_en_o [*8])
    else $error("restart too early");
  COV_TRIP: cover property ($fell(inv_en_o) && sw_on_i);
  COV_VLIM: cover property (vlim_o);
  COV_EVT: cover property (event_o);
  COV_ACK: cover property (wb_ack_o);
endmodule : inverter_protection_restart_chk
`default_nettype wire

//--- verification/inverter_protection_restart_tb.sv
// self-checking bench for the inverter protection block
`default_nettype none
`include "prot_cfg.svh"
module inverter_protection_restart_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, stb, we, go, day, ack, epl, busy, inv_en, chg_en, chg_allow, evt, ok;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] lv, pin, n_q;
  logic [15:0] v, bv, vmax, vmin;
  int err_total, checks_done, t, t0, evts, c, k, n, n1;
  logic vl, vlim;
  int codes[$];

  inverter_protection_restart #(.SEC_CYC(20), .OC_CYC(8), .RESTART_S(3)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sw_on_i(pin[0]), .oc_i(pin[1]), .hv_i(pin[2]), .ot_i(pin[3]), .epl_i(epl),
    .batt_v_i(bv), .day_tick_i(day), .inv_en_o(inv_en), .chg_en_o(chg_en),
    .chg_allow_o(chg_allow), .vlim_o(vlim), .event_o(evt));
  power_stage_model psm (.clk_i(clk_i), .lv_i(lv), .v_i(v), .n_i(n_q), .go_i(go),
    .pin_o(pin), .batt_v_o(bv), .epl_o(epl), .busy_o(busy));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    t <= t + 1;
    if (evt === 1'b1) evts++;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // no own limit: only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic setv(input logic [15:0] x);
    v <= x;
    if (x > vmax) vmax = x;
    if (x < vmin) vmin = x;
  endtask : setv
  task automatic rise(input int b);
    while (inv_en !== 1'b1 && t - t0 < b) @(posedge clk_i);
    n = t - t0;
  endtask : rise
  task automatic pulses(input logic [3:0] m);
    n_q <= m;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    while (busy === 1'b1) @(posedge clk_i);
    repeat (8) @(posedge clk_i);
  endtask : pulses
  // apply a fault, clear its flag, remove it and time the restart
  task automatic trip(input int cs, input logic [15:0] hi);
    @(posedge clk_i);
    if (cs == 2) setv(16'd2000 + 16'($urandom % 1000));
    else lv[cs == 1 ? 1 : cs - 1] <= 1'b1;
    codes.push_back(cs);
    vl = 1'b0;
    t0 = t;
    while (inv_en !== 1'b0 && t - t0 < 100) begin
      @(posedge clk_i);
      if (vlim === 1'b1) vl = 1'b1;
    end
    t0 = t;
    chk({31'h0, inv_en}, 32'h0);
    chk({31'h0, vl}, {31'h0, cs == 1});
    if (cs == 2) begin
      chk({31'h0, chg_en}, 32'h1);
      chk({31'h0, chg_allow}, 32'h0);
    end
    rd(`A_STICKY, 32'h1 << (cs - 1));
    wb(1'b1, `A_STICKY, 32'h1 << (cs - 1));
    // high battery stays until well past the hold time
    if (cs == 3) while (t - t0 < 100) @(posedge clk_i);
    lv <= 4'h1;
    setv(hi);
    rise(300);
  endtask : trip

  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    wdat = 32'h0;
    go = 1'b0;
    day = 1'b0;
    n_q = 4'h0;
    lv = 4'h1;
    v = 16'd4800;
    rst_i = 1'b1;
    void'($urandom(32'h83f3));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`A_CTRL, 32'h2);
    rd(`A_TH_SHUT, 32'h0e88);
    rd(`A_TH_REST, 32'h1108);
    rd(8'h3c, 32'h0);
    n1 = 3700 + $urandom % 200;
    wb(1'b1, `A_TH_SHUT, 32'(n1));
    rd(`A_TH_SHUT, 32'(n1));
    chk({31'h0, inv_en}, 32'h1);
    day <= 1'b1;
    @(posedge clk_i);
    day <= 1'b0;
    vmax = v;
    vmin = v;
    n1 = 1 + $urandom % 8;
    pulses(4'(n1));
    rd(`A_E_TOTAL, 32'(n1));
    rd(`A_E_SINCE, 32'(n1));
    wb(1'b1, `A_CTRL, 32'h6);
    wb(1'b1, `A_E_TOTAL, 32'h0);
    pulses(4'h5);
    rd(`A_E_TOTAL, 32'(n1 + 5));
    rd(`A_E_SINCE, 32'h5);
    $display("test registers and energy done");
    for (c = 1; c <= 4; c++) begin
      if (c == 2) wb(1'b1, `A_CTRL, 32'h1);
      for (k = 1; k <= (c == 4 ? 5 : 4); k++) begin
        trip(c, (c == 2 && k == 4) ? 16'd4380 : 16'd4500 + 16'($urandom % 500));
        ok = (c <= 2 && k == 4) ? n >= 300 : (c == 3 ? n >= 100 && n <= 116 : n >= 59 && n <= 90);
        chk({31'h0, ok}, 32'h1);
      end
      if (c == 1) begin
        wb(1'b0, `A_STATUS, 32'h0);
        chk({29'h0, q[2:0]}, 32'h6);
        lv <= 4'h0;
        repeat (10) @(posedge clk_i);
        lv <= 4'h1;
        t0 = t;
        rise(20);
        chk({31'h0, inv_en}, 32'h1);
        wb(1'b0, `A_STATUS, 32'h0);
        chk({28'h0, q[7:4]}, 32'h0);
      end
      if (c == 2) begin
        wb(1'b0, `A_STATUS, 32'h0);
        chk({29'h0, q[2:0]}, 32'h7);
        setv(16'd4500);
        t0 = t;
        rise(300);
        chk({31'h0, n >= 59 && n <= 90}, 32'h1);
        chk({31'h0, chg_en}, 32'h0);
        wb(1'b1, `A_CTRL, 32'h2);
      end
      repeat (100) @(posedge clk_i);
      $display("test cause %0d done", c);
    end
    q = {8'h00, 8'(codes.size()), 4'(codes[$-3]), 4'(codes[$-2]), 4'(codes[$-1]), 4'(codes[$])};
    rd(`A_DAY_ERR, q);
    rd(`A_DAY_V, {vmax, vmin});
    chk(32'(evts), 32'(codes.size()));
    test_done;
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    test_done;
  end
endmodule : inverter_protection_restart_tb

bind inverter_protection_restart inverter_protection_restart_chk chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .sw_on_i(sw_on_i), .oc_i(oc_i), .hv_i(hv_i), .ot_i(ot_i),
  .inv_en_o(inv_en_o), .chg_en_o(chg_en_o), .chg_allow_o(chg_allow_o),
  .vlim_o(vlim_o), .event_o(event_o));
`default_nettype wire

//--- verification/power_stage_model.sv
// model of the sensing comparators, battery and user switch
`default_nettype none
module power_stage_model (
  input wire logic clk_i,         // system clock
  input wire logic [3:0] lv_i,    // wanted {ot, hv, oc, sw}
  input wire logic [15:0] v_i,    // wanted battery level
  input wire logic [3:0] n_i,     // quanta in a burst
  input wire logic go_i,          // start a burst
  output logic [3:0] pin_o,       // pins {ot, hv, oc, sw}
  output logic [15:0] batt_v_o,   // sensed battery level
  output logic epl_o,             // energy quantum pulse
  output logic busy_o             // burst running
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] cnt;
  initial begin
    pin_o = 4'h0;
    batt_v_o = 16'h0;
    epl_o = 1'b0;
    cnt = 7'h0;
  end
  // four high, four low per quantum, wider than the sync needs
  always @(posedge clk_i) begin
    pin_o <= lv_i;
    batt_v_o <= v_i;
    epl_o <= cnt != 7'h0 && cnt[2];
    if (go_i)
      cnt <= {n_i, 3'h0};
    else if (cnt != 7'h0)
      cnt <= cnt - 7'h1;
  end
  assign busy_o = cnt != 7'h0 || epl_o;
endmodule : power_stage_model
`default_nettype wire
